//--- rtl/sar_readout.sv
// Behaviour
// R1: select low active, high means shutdown
// R2: result word is twelve bits
// R3: output bits valid at clock falling edge
// R4: output enabled on second falling edge
// R5: one null bit precedes result bits
// R6: host clock paces transfer and conversion
// R7: host clock between 10 kHz, 3.2 MHz
// R8: capture input difference when conversion begins
// R9: result shifted out MSB first
// R10: output bits belong to current conversion
// R11: extra clocks repeat word LSB first
// R12: inverting input sampled once per conversion
// R13: acquire for first two clock periods
// R14: after repeated MSB, release and ignore
// R15: new conversion only after select toggles
// R16: result is unsigned straight binary
// R17: select high: output off, clocks ignored
// R18: host supplies null plus twelve clocks
`timescale 1ns/1ps
`default_nettype none

module sar_fifo #(
    parameter int W = 12,
    parameter int DEPTH = 32
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic [W-1:0] in_data,
    input wire logic in_valid,
    output logic in_ready,
    output logic [W-1:0] out_data,
    output logic out_valid,
    input wire logic out_ready
);
    localparam int AW = $clog2(DEPTH);
    logic [W-1:0] mem [DEPTH];
    logic [AW-1:0] wr_q;
    logic [AW-1:0] rd_q;
    logic [AW:0] cnt_q;
    logic push;
    logic pop;

    // Count is one bit wider than the address so that a full buffer is told from an empty one
    assign in_ready = (cnt_q != (AW+1)'(DEPTH));
    assign push = in_valid && in_ready;
    // Output register refills whenever it is empty or being taken
    assign pop = (cnt_q != '0) && (!out_valid || out_ready);

    always_ff @(posedge mclk) begin
        if (push) begin
            mem[wr_q] <= in_data;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            wr_q <= '0;
            rd_q <= '0;
            cnt_q <= '0;
        end else begin
            if (push) begin
                wr_q <= wr_q + 1'b1;
            end
            if (pop) begin
                rd_q <= rd_q + 1'b1;
            end
            if (push && !pop) begin
                cnt_q <= cnt_q + 1'b1;
            end else if (pop && !push) begin
                cnt_q <= cnt_q - 1'b1;
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            out_valid <= 1'b0;
            out_data <= '0;
        end else if (pop) begin
            out_valid <= 1'b1;
            out_data <= mem[rd_q];
        end else if (out_ready) begin
            out_valid <= 1'b0;
        end
    end
endmodule // sar_fifo

module sar_readout (
    input wire logic mclk,
    input wire logic rst,
    input wire logic select_shutdown_n,
    input wire logic conversion_clock,
    input wire logic [11:0] in_pos,
    input wire logic [11:0] in_neg,
    output logic dout,
    output logic dout_oe,
    output logic [11:0] result_data,
    output logic result_valid,
    input wire logic result_ready
);
    sar_pkg::sar_state_t state_q;
    logic [1:0] sel_sync_q;
    logic [2:0] clk_sync_q;
    logic sel_prev_q;
    logic [11:0] pos_s1_q;
    logic [11:0] pos_q;
    logic [11:0] neg_s1_q;
    logic [11:0] neg_q;
    logic acq_seen_q;
    logic [3:0] idx_q;
    logic [11:0] diff_q;
    logic [11:0] sar_q;
    logic dout_q;
    logic dout_oe_q;
    logic push_q;
    logic [11:0] push_data_q;
    logic fifo_ready;
    logic sel_hi;
    logic sel_fall;
    logic clk_fall;
    logic [11:0] diff_d;
    logic [11:0] trial;
    logic bit_dec;

    // Pins come from the host's domain; two stages before use
    always_ff @(posedge mclk) begin
        if (rst) begin
            sel_sync_q <= 2'h3;
            clk_sync_q <= 3'h0;
            sel_prev_q <= 1'b1;
        end else begin
            sel_sync_q <= {sel_sync_q[0], select_shutdown_n};
            clk_sync_q <= {clk_sync_q[1:0], conversion_clock};
            sel_prev_q <= sel_sync_q[1];
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            pos_s1_q <= sar_pkg::WORD_ZERO;
            pos_q <= sar_pkg::WORD_ZERO;
            neg_s1_q <= sar_pkg::WORD_ZERO;
            neg_q <= sar_pkg::WORD_ZERO;
        end else begin
            pos_s1_q <= in_pos;
            pos_q <= pos_s1_q;
            neg_s1_q <= in_neg;
            neg_q <= neg_s1_q;
        end
    end

    assign sel_hi = sel_sync_q[1]; // [R1]
    assign sel_fall = sel_prev_q && !sel_sync_q[1];
    assign clk_fall = clk_sync_q[2] && !clk_sync_q[1]; // [R6]
    // Negative differences clamp to code zero [R16]
    assign diff_d = (pos_q >= neg_q) ? (pos_q - neg_q) : sar_pkg::WORD_ZERO;
    assign trial = sar_q | (sar_pkg::WORD_ONE << idx_q);
    assign bit_dec = (diff_q >= trial);

    always_ff @(posedge mclk) begin
        if (rst) begin
            state_q <= sar_pkg::SAR_IDLE;
            acq_seen_q <= 1'b0;
            idx_q <= sar_pkg::IDX_MSB;
        end else if (sel_hi) begin
            state_q <= sar_pkg::SAR_IDLE; // [R17]
        end else begin
            case (state_q)
                sar_pkg::SAR_IDLE: begin
                    // Start is refused while the result FIFO is full [R15]
                    if (sel_fall) begin
                        state_q <= fifo_ready ? sar_pkg::SAR_ACQ : sar_pkg::SAR_DONE;
                        acq_seen_q <= 1'b0;
                    end
                end
                sar_pkg::SAR_ACQ: begin
                    if (clk_fall) begin
                        acq_seen_q <= 1'b1;
                        if (acq_seen_q) begin
                            state_q <= sar_pkg::SAR_MSB; // [R13]
                            idx_q <= sar_pkg::IDX_MSB;
                        end
                    end
                end
                sar_pkg::SAR_MSB: begin
                    if (clk_fall) begin
                        if (idx_q == sar_pkg::IDX_LSB) begin
                            state_q <= sar_pkg::SAR_LSB;
                            idx_q <= sar_pkg::IDX_STEP;
                        end else begin
                            idx_q <= idx_q - sar_pkg::IDX_STEP;
                        end
                    end
                end
                sar_pkg::SAR_LSB: begin
                    if (clk_fall) begin
                        if (idx_q == sar_pkg::IDX_MSB) begin
                            state_q <= sar_pkg::SAR_DONE;
                        end else begin
                            idx_q <= idx_q + sar_pkg::IDX_STEP;
                        end
                    end
                end
                sar_pkg::SAR_DONE: begin
                    state_q <= sar_pkg::SAR_DONE; // [R14]
                end
                default: begin
                    state_q <= sar_pkg::SAR_IDLE;
                end
            endcase
        end
    end

    // Held difference is taken once, at the end of acquisition [R8] [R12]
    always_ff @(posedge mclk) begin
        if (rst) begin
            diff_q <= sar_pkg::WORD_ZERO;
        end else if (!sel_hi && state_q == sar_pkg::SAR_ACQ && clk_fall && acq_seen_q) begin
            diff_q <= diff_d;
        end
    end

    // One decision per falling edge, shown the same edge [R6] [R10]
    always_ff @(posedge mclk) begin
        if (rst) begin
            sar_q <= sar_pkg::WORD_ZERO;
        end else if (!sel_hi && state_q == sar_pkg::SAR_ACQ && clk_fall) begin
            sar_q <= sar_pkg::WORD_ZERO;
        end else if (!sel_hi && state_q == sar_pkg::SAR_MSB && clk_fall && bit_dec) begin
            sar_q <= trial;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            dout_q <= 1'b0;
            dout_oe_q <= 1'b0;
        end else if (sel_hi) begin
            dout_oe_q <= 1'b0; // [R1] [R17]
        end else if (clk_fall) begin
            case (state_q)
                sar_pkg::SAR_ACQ: begin
                    if (acq_seen_q) begin
                        dout_oe_q <= 1'b1; // [R4]
                        dout_q <= 1'b0; // [R5]
                    end
                end
                sar_pkg::SAR_MSB: begin
                    dout_q <= bit_dec; // [R3] [R9]
                end
                sar_pkg::SAR_LSB: begin
                    dout_q <= sar_q[idx_q]; // [R11]
                end
                sar_pkg::SAR_DONE: begin
                    dout_oe_q <= 1'b0; // [R14]
                end
                default: begin
                    dout_oe_q <= 1'b0;
                end
            endcase
        end
    end

    // Completed 12-bit word also goes to the user side [R2]
    always_ff @(posedge mclk) begin
        if (rst) begin
            push_q <= 1'b0;
            push_data_q <= sar_pkg::WORD_ZERO;
        end else begin
            push_q <= !sel_hi && state_q == sar_pkg::SAR_MSB && clk_fall
                && idx_q == sar_pkg::IDX_LSB;
            push_data_q <= bit_dec ? trial : sar_q;
        end
    end

    sar_fifo #(.W(sar_pkg::RES_W), .DEPTH(sar_pkg::FIFO_DEPTH)) u_fifo (
        .mclk(mclk),
        .rst(rst),
        .in_data(push_data_q),
        .in_valid(push_q),
        .in_ready(fifo_ready),
        .out_data(result_data),
        .out_valid(result_valid),
        .out_ready(result_ready)
    );

    assign dout = dout_q;
    assign dout_oe = dout_oe_q;

    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);

    sequence s_second_fall;
        !sel_hi && state_q == sar_pkg::SAR_ACQ && clk_fall && acq_seen_q;
    endsequence
    sequence s_first_fall;
        !sel_hi && state_q == sar_pkg::SAR_ACQ && clk_fall && !acq_seen_q;
    endsequence

    chk_shutdown_hiz: assert property (sel_hi |=> !dout_oe_q) // [R1] [R17]
        else $error("output driven during shutdown");
    chk_null_bit: assert property (s_second_fall |=> dout_oe_q && !dout_q) // [R4] [R5]
        else $error("null bit missing after second fall");
    chk_acq_quiet: assert property (state_q == sar_pkg::SAR_ACQ |-> !dout_oe_q) // [R4]
        else $error("output enabled during acquisition");
    chk_acq_length: assert property (s_first_fall |=> state_q == sar_pkg::SAR_ACQ) // [R13]
        else $error("acquisition ended too early");
    chk_sample_once: assert property ( // [R8] [R12]
        !(!sel_hi && state_q == sar_pkg::SAR_ACQ && clk_fall && acq_seen_q)
        |=> $stable(diff_q))
        else $error("held difference changed mid conversion");
    chk_msb_order: assert property ( // [R9] [R10] [R16]
        !sel_hi && state_q == sar_pkg::SAR_MSB && clk_fall
        |=> dout_q == diff_q[$past(idx_q)])
        else $error("MSB-first bit wrong");
    chk_lsb_repeat: assert property ( // [R11]
        !sel_hi && state_q == sar_pkg::SAR_LSB && clk_fall
        |=> dout_q == diff_q[$past(idx_q)])
        else $error("LSB-first repeat wrong");
    chk_word_value: assert property (push_q |-> push_data_q == diff_q) // [R2]
        else $error("result word differs from held input");
    chk_release: assert property (state_q == sar_pkg::SAR_DONE && clk_fall |=> !dout_oe_q) // [R14]
        else $error("output not released after repeat");
    chk_new_conv: assert property ( // [R15]
        state_q == sar_pkg::SAR_IDLE && !sel_fall
        |=> state_q == sar_pkg::SAR_IDLE)
        else $error("conversion started without select toggle");
    chk_edge_only: assert property (!clk_fall |=> $stable(dout_q) && $stable(sar_q)) // [R3] [R6]
        else $error("output moved without clock fall");
endmodule // sar_readout

`default_nettype wire

//--- rtl/sar_pkg.sv
package sar_pkg;
    localparam int RES_W = 12;
    localparam int FIFO_DEPTH = 32;
    localparam logic [3:0] IDX_MSB = 4'hb;
    localparam logic [3:0] IDX_LSB = 4'h0;
    localparam logic [3:0] IDX_STEP = 4'h1;
    localparam logic [RES_W-1:0] WORD_ZERO = 12'h000;
    localparam logic [RES_W-1:0] WORD_ONE = 12'h001;

    typedef enum logic [2:0] {
        SAR_IDLE = 3'b000,
        SAR_ACQ = 3'b001,
        SAR_MSB = 3'b010,
        SAR_LSB = 3'b011,
        SAR_DONE = 3'b100
    } sar_state_t;
endpackage

//--- dv/sar_host.sv
`timescale 1ns/1ps
`default_nettype none

module sar_host (
    input wire logic mclk,
    input wire logic dout_pin,
    input wire logic dout_oe,
    output logic select_shutdown_n,
    output logic conversion_clock
);
    initial begin
        select_shutdown_n = 1'b1;
        conversion_clock = 1'b0;
    end

    // Half period of 8 to 2000 mclk keeps the clock in its legal band
    // Clock idles low between frames; captures on the rising edge
    task automatic frame(input int nfall, input int half, input int abort_at,
                         output logic [31:0] bits, output logic [31:0] oe);
        bits = '0;
        oe = '0;
        select_shutdown_n = 1'b0;
        repeat (half) @(negedge mclk);
        for (int k = 0; k < nfall; k++) begin
            if (k == abort_at) select_shutdown_n = 1'b1;
            conversion_clock = 1'b1;
            repeat (half) @(negedge mclk);
            conversion_clock = 1'b0;
            repeat (half) @(negedge mclk);
            bits[k] = dout_pin;
            oe[k] = dout_oe;
        end
        select_shutdown_n = 1'b1; // Fresh select edge for every sample
        repeat (2 * half) @(negedge mclk);
    endtask
endmodule // sar_host

`default_nettype wire

//--- dv/sar_readout_tb.sv
`timescale 1ns/1ps
`default_nettype none

module sar_readout_tb;
    logic mclk = 1'b0;
    logic rst = 1'b1;
    logic [11:0] in_pos = 12'h000;
    logic [11:0] in_neg = 12'h000;
    logic result_ready = 1'b0;
    logic last_q = 1'b0;
    wire logic sel_n;
    wire logic dclk;
    wire logic dout;
    wire logic dout_oe;
    wire logic [11:0] result_data;
    wire logic result_valid;
    wire logic dout_pin;
    logic [31:0] b;
    logic [31:0] o;
    int n_fail = 0;
    int n_compared = 0;

    always #12.5 mclk = ~mclk;

    // Undriven pin shows the inverse of its last level, never a stale copy
    always @(posedge mclk) if (dout_oe) last_q <= dout;
    assign dout_pin = dout_oe ? dout : ~last_q;

    sar_readout uut (
        .mclk(mclk), .rst(rst), .select_shutdown_n(sel_n), .conversion_clock(dclk),
        .in_pos(in_pos), .in_neg(in_neg), .dout(dout), .dout_oe(dout_oe),
        .result_data(result_data), .result_valid(result_valid),
        .result_ready(result_ready)
    );

    sar_host host (
        .mclk(mclk), .dout_pin(dout_pin), .dout_oe(dout_oe),
        .select_shutdown_n(sel_n), .conversion_clock(dclk)
    );

    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        n_compared++;
        if (seen !== exp) begin
            n_fail++;
            $display("CHECK FAILED %0t %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask

    function automatic logic [31:0] exp_dout(input logic [11:0] w);
        logic [31:0] e;
        e = '0;
        for (int i = 0; i < 12; i++) e[2 + i] = w[11 - i];
        for (int i = 1; i < 12; i++) e[13 + i] = w[i];
        return e;
    endfunction

    task automatic take(input logic [11:0] w);
        int n;
        n = 0;
        while (result_valid !== 1'b1 && n < 200) begin
            @(negedge mclk);
            n++;
        end
        check(result_valid, 1'b1, "valid");
        check(result_data, w, "word");
        result_ready = 1'b1;
        @(negedge mclk);
        result_ready = 1'b0;
    endtask

    // Inputs move after acquisition; the word must still match the held sample
    task automatic t_full;
        logic [11:0] p[3] = '{12'hfff, 12'h005, 12'ha5c};
        logic [11:0] q[3] = '{12'h000, 12'h009, 12'h123};
        logic [11:0] w[3] = '{12'hfff, 12'h000, 12'h939};
        for (int i = 0; i < 3; i++) begin
            in_pos = p[i];
            in_neg = q[i];
            fork
                host.frame(28, 8 + 12 * (i % 2), 99, b, o);
                begin
                    repeat (7 * (8 + 12 * (i % 2))) @(negedge mclk);
                    in_pos = ~p[i];
                    in_neg = 12'h000;
                end
            join
            check(o, 32'h01fffffe, "enable");
            check(b & o, exp_dout(w[i]), "serial");
            take(w[i]);
        end
    endtask

    task automatic t_abort;
        in_pos = 12'h7ff;
        host.frame(20, 8, 6, b, o);
        check(o[5:1], 5'h1f, "active");
        check(o[19:6], 14'h0000, "shutdown");
        repeat (100) @(negedge mclk);
        check(result_valid, 1'b0, "no word");
    endtask

    // Buffer plus its output register hold 33 words; the next start is refused
    task automatic t_fifo;
        in_neg = 12'h0ff;
        for (int i = 0; i < 33; i++) begin
            in_pos = 12'h100 + 12'(i);
            host.frame(15, 8, 99, b, o);
        end
        host.frame(15, 8, 99, b, o);
        check(o, 32'h0, "refused");
        for (int i = 0; i < 33; i++) begin
            repeat (i % 3) @(negedge mclk);
            take(12'(i + 1));
        end
        repeat (5) @(negedge mclk);
        check(result_valid, 1'b0, "drained");
    endtask

    task automatic summarize;
        $display("checks %0d failures %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    initial begin
        repeat (20) @(negedge mclk);
        rst = 1'b0;
        repeat (5) @(negedge mclk);
        t_full;
        t_abort;
        t_fifo;
        summarize;
    end

    initial begin
        repeat (60000) @(posedge mclk);
        n_fail++;
        $display("CHECK FAILED %0t watchdog expired", $time);
        summarize;
    end
endmodule // sar_readout_tb

`default_nettype wire
